/* File: hdl/dieh_pkg.sv */
// constants, decode patterns and register map for the divide / irq-enable / halt decoder
// Operation
// - The unsigned divide takes all 32 bits of the first operand as divisor, writes quotient to the second operand register and remainder to the third.
// - The unsigned divide is decoded from divisor and dividend fields with bits 111111 in the low halfword and remainder field plus 01011000010 in the high halfword.
// - A zero divisor sets the overflow flag with an undefined quotient, otherwise overflow clears, and carry and saturation stay unchanged.
// - After a divide the sign flag follows a negative result and the zero flag a zero result, each cleared otherwise.
// - The divide never writes the divisor register, and when quotient and remainder share a register the remainder is what remains there.
// - An interrupt during a divide aborts it, the return address is the divide itself, and both source registers keep their old values.
// - The interrupt-enable instruction clears the interrupt mask bit so maskable interrupts are taken from the next instruction, leaving all other flags alone.
// - The interrupt-enable instruction is decoded from the fixed pattern 1000011111100000 low and 0000000101100000 high.
// - Pending interrupts are sampled at instruction boundaries, partway through a divide (which they abort), and while halted.
// - The halt instruction stops the core clock and enters halted mode without changing any flag, decoded from 0000011111100000 low and 000000100100000 high.
// - Halted mode ends only on reset, a non-maskable request, or an unmasked maskable request.
// - An interrupt taken while halted saves the address after the halt in the maskable or fatal return register.
package dieh_pkg;
   localparam int          DATA_W          = 32;
   localparam int          REG_AW          = 5;
   localparam int          BUS_AW          = 8;
   // instruction patterns
   localparam logic [5:0]  UDIV_LO_OP      = 6'h3F;
   localparam logic [10:0] UDIV_HI_OP      = 11'h2C2;
   localparam logic [15:0] UNMASK_LO       = 16'h87E0;
   localparam logic [15:0] UNMASK_HI       = 16'h0160;
   localparam logic [15:0] HALT_LO         = 16'h07E0;
   localparam logic [14:0] HALT_HI         = 15'h0120;
   // instruction field positions
   localparam int          DIVISOR_LSB     = 0;
   localparam int          DIVIDEND_LSB    = 11;
   localparam int          REMAINDER_LSB   = 27;
   localparam logic [31:0] INSTR_BYTES     = 32'h0000_0004;
   // program status word bit positions
   localparam int          PSTW_ZERO       = 0;
   localparam int          PSTW_SIGN       = 1;
   localparam int          PSTW_RANGE_ERR  = 2;
   localparam int          PSTW_CARRY      = 3;
   localparam int          PSTW_CLAMP      = 4;
   localparam int          PSTW_IRQ_MASK   = 5;
   localparam int          PSTW_W          = 6;
   localparam logic [5:0]  PSTW_RESET      = 6'h20;
   // register map, byte offsets
   localparam logic [7:0]  OFS_STATUS      = 8'h00;
   localparam logic [7:0]  OFS_MASK        = 8'h04;
   localparam logic [7:0]  OFS_PSTW        = 8'h08;
   localparam logic [7:0]  OFS_IRQ_PC      = 8'h0C;
   localparam logic [7:0]  OFS_FATAL_PC    = 8'h10;
   // status event bits
   localparam int          EV_DIV_DONE     = 0;
   localparam int          EV_DIV_ZERO     = 1;
   localparam int          EV_DIV_ABORT    = 2;
   localparam int          EV_HALT_EXIT    = 3;
   localparam int          EV_W            = 4;
   localparam logic [3:0]  STATUS_RESET    = 4'h0;
   localparam logic [3:0]  MASK_RESET      = 4'h0;
   localparam logic [31:0] PC_RESET        = 32'h0000_0000;
   localparam int          DIV_CYCLES      = 32;
   typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_HALT} dieh_state_t;
endpackage : dieh_pkg

/* File: hdl/dieh_div_if.sv */
// handshake between the decoder and the iterative divider
`timescale 1ns/1ps
interface dieh_div_if #(parameter int W = 32);
   logic         start;
   logic         abort;
   logic [W-1:0] dividend;
   logic [W-1:0] divisor;
   logic         done;
   logic [W-1:0] quotient;
   logic [W-1:0] remainder;
   modport ctrl (output start, abort, dividend, divisor, input done, quotient, remainder);
   modport unit (input start, abort, dividend, divisor, output done, quotient, remainder);
endinterface : dieh_div_if

/* File: hdl/dieh_divider.sv */
// restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
module dieh_divider
   import dieh_pkg::*;
#(
   parameter int W = 32
) (
   input  wire logic CLK_I,     // core clock
   input  wire logic RST_B_I,   // async reset, active low
   dieh_div_if.unit  div        // request and result
);
   logic [W-1:0]         quo;
   logic [W-1:0]         rem;
   logic [W-1:0]         dsr;
   logic [$clog2(W+1)-1:0] cnt;
   logic                 busy;
   logic [W:0]           trial;
   logic [W:0]           shifted;

   // one restoring step
   assign shifted       = {rem, quo[W-1]};
   assign trial         = shifted - {1'b0, dsr};
   assign div.quotient  = quo;
   assign div.remainder = rem;

   // iteration; abort drops the work without a done pulse
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         quo      <= '0;
         rem      <= '0;
         dsr      <= '0;
         cnt      <= '0;
         busy     <= 1'b0;
         div.done <= 1'b0;
      end else begin
         div.done <= 1'b0;
         if (div.abort) begin
            busy <= 1'b0;
         end else if (div.start) begin
            quo  <= div.dividend;
            rem  <= '0;
            dsr  <= div.divisor;
            cnt  <= ($clog2(W+1))'(W);
            busy <= 1'b1;
         end else if (busy) begin
            if (trial[W]) begin
               rem <= shifted[W-1:0];
               quo <= {quo[W-2:0], 1'b0};
            end else begin
               rem <= trial[W-1:0];
               quo <= {quo[W-2:0], 1'b1};
            end
            cnt <= cnt - 1'b1;
            if (cnt == 1) begin
               busy     <= 1'b0;
               div.done <= 1'b1;
            end
         end
      end
   end
endmodule : dieh_divider

/* File: hdl/dieh_decoder.sv */
// decoder and sequencer for unsigned divide, interrupt unmask and halt
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module dieh_decoder
   import dieh_pkg::*;
(
   input  wire logic              CLK_I,         // core clock, 100 MHz
   input  wire logic              RST_B_I,       // async reset, active low
   input  wire logic [31:0]       INSTR_I,       // instruction word
   input  wire logic              INSTR_VALID_I, // instruction offered
   input  wire logic [31:0]       PC_I,          // address of offered instruction
   input  wire logic [31:0]       DIVIDEND_I,    // dividend register value
   input  wire logic [31:0]       DIVISOR_I,     // divisor register value
   input  wire logic              IRQ_I,         // maskable request pin
   input  wire logic              NMI_I,         // non-maskable request pin
   input  wire logic [7:0]        REG_ADDR_I,    // register byte address
   input  wire logic [31:0]       REG_WDATA_I,   // register write data
   input  wire logic              REG_WR_I,      // register write strobe
   input  wire logic              REG_RD_I,      // register read strobe
   output logic [31:0]            REG_RDATA_O,   // read data, cycle after strobe
   output logic                   INSTR_READY_O, // idle, may offer instruction
   output logic                   Q_WE_O,        // quotient write pulse
   output logic [4:0]             Q_ADDR_O,      // quotient register number
   output logic [31:0]            Q_DATA_O,      // quotient value
   output logic                   R_WE_O,        // remainder write pulse
   output logic [4:0]             R_ADDR_O,      // remainder register number
   output logic [31:0]            R_DATA_O,      // remainder value
   output logic                   RETIRE_O,      // instruction completed
   output logic                   IRQ_ACK_O,     // maskable interrupt taken
   output logic                   NMI_ACK_O,     // non-maskable interrupt taken
   output logic [31:0]            IRQ_PC_O,      // maskable return address
   output logic [31:0]            FATAL_PC_O,    // fatal return address
   output logic [5:0]             PSTW_O,        // program status word
   output logic                   CORE_CLK_EN_O, // core clock enable
   output logic                   INT_O          // event interrupt, level
);
   dieh_div_if #(.W(DATA_W)) div ();

   dieh_state_t          state;
   dieh_state_t          next_state;
   logic [2:0]           irq_sync;
   logic [2:0]           nmi_sync;
   logic                 irq_lvl;
   logic                 nmi_lvl;
   logic                 nmi_seen;
   logic [31:0]          op_pc;
   logic [4:0]           q_reg;
   logic [4:0]           r_reg;
   logic                 dsr_zero;
   logic [EV_W-1:0]      status;
   logic [EV_W-1:0]      mask;
   logic [EV_W-1:0]      events;
   logic [5:0]           pstw;
   logic [31:0]          irq_pc;
   logic [31:0]          fatal_pc;

   // instruction pattern matches
   function automatic logic is_udiv(input logic [31:0] ins);
      return (ins[10:5] == UDIV_LO_OP) && (ins[26:16] == UDIV_HI_OP);
   endfunction : is_udiv

   function automatic logic is_unmask(input logic [31:0] ins);
      return (ins[15:0] == UNMASK_LO) && (ins[31:16] == UNMASK_HI);
   endfunction : is_unmask

   function automatic logic is_halt(input logic [31:0] ins);
      return (ins[15:0] == HALT_LO) && (ins[30:16] == HALT_HI);
   endfunction : is_halt

   // decode and interrupt qualification
   wire  issue     = INSTR_VALID_I && (state == ST_IDLE);
   wire  dec_div   = is_udiv(INSTR_I);
   wire  dec_unm   = is_unmask(INSTR_I);
   wire  dec_halt  = is_halt(INSTR_I);
   wire  nmi_new   = nmi_lvl && !nmi_seen;
   wire  irq_ok    = irq_lvl && !pstw[PSTW_IRQ_MASK];
   wire  take_int  = nmi_new || irq_ok;
   wire  take_nmi  = nmi_new;
   wire  int_idle  = issue && take_int;
   wire  int_div   = (state == ST_DIV) && take_int && !div.done;
   wire  int_halt  = (state == ST_HALT) && take_int;
   wire  any_int   = int_idle || int_div || int_halt;
   wire  start_div = issue && !take_int && dec_div;
   wire  do_unmask = issue && !take_int && dec_unm;
   wire  do_halt   = issue && !take_int && dec_halt;
   wire  same_dst  = (q_reg == r_reg);
   wire  hit_st    = REG_ADDR_I == OFS_STATUS;
   wire  hit_mask  = REG_ADDR_I == OFS_MASK;
   wire  hit_pstw  = REG_ADDR_I == OFS_PSTW;
   wire  hit_ipc   = REG_ADDR_I == OFS_IRQ_PC;
   wire  hit_fpc   = REG_ADDR_I == OFS_FATAL_PC;
   wire  [31:0] ret_pc = (state == ST_HALT) ? op_pc + INSTR_BYTES : (issue ? PC_I : op_pc);

   // divider hookup; sources are copied, so register file stays intact on abort
   assign div.start    = start_div;
   assign div.abort    = int_div;
   assign div.dividend = DIVIDEND_I;
   assign div.divisor  = DIVISOR_I;

   dieh_divider #(.W(DATA_W)) u_div (
      .CLK_I   (CLK_I),
      .RST_B_I (RST_B_I),
      .div     (div)
   );

   // status events
   assign events = {int_halt,
                    int_div,
                    div.done && dsr_zero,
                    div.done && !int_div};

   // sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_div) begin
               next_state = ST_DIV;
            end else if (do_halt) begin
               next_state = ST_HALT;
            end
         end
         ST_DIV: begin
            if (int_div || div.done) begin
               next_state = ST_IDLE;
            end
         end
         ST_HALT: begin
            if (int_halt) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // pin synchronisers, change counted when stages two and three agree
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         irq_sync <= 3'h0;
         nmi_sync <= 3'h0;
         irq_lvl  <= 1'b0;
         nmi_lvl  <= 1'b0;
      end else begin
         irq_sync <= {irq_sync[1:0], IRQ_I};
         nmi_sync <= {nmi_sync[1:0], NMI_I};
         if (irq_sync[1] == irq_sync[2]) begin
            irq_lvl <= irq_sync[2];
         end
         if (nmi_sync[1] == nmi_sync[2]) begin
            nmi_lvl <= nmi_sync[2];
         end
      end
   end

   // state, operand capture and nmi edge memory
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state    <= ST_IDLE;
         op_pc    <= PC_RESET;
         q_reg    <= 5'h00;
         r_reg    <= 5'h00;
         dsr_zero <= 1'b0;
         nmi_seen <= 1'b0;
      end else begin
         state <= next_state;
         if (issue) begin
            op_pc    <= PC_I;
            q_reg    <= INSTR_I[DIVIDEND_LSB +: REG_AW];
            r_reg    <= INSTR_I[REMAINDER_LSB +: REG_AW];
            dsr_zero <= (DIVISOR_I == 32'h0000_0000);
         end
         if (any_int && take_nmi) begin
            nmi_seen <= 1'b1;
         end else if (!nmi_lvl) begin
            nmi_seen <= 1'b0;
         end
      end
   end

   // result write-back, only on an unaborted finish
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         Q_WE_O   <= 1'b0;
         Q_ADDR_O <= 5'h00;
         Q_DATA_O <= 32'h0000_0000;
         R_WE_O   <= 1'b0;
         R_ADDR_O <= 5'h00;
         R_DATA_O <= 32'h0000_0000;
         RETIRE_O <= 1'b0;
      end else begin
         Q_WE_O   <= div.done && !same_dst;
         R_WE_O   <= div.done;
         Q_ADDR_O <= q_reg;
         R_ADDR_O <= r_reg;
         Q_DATA_O <= div.quotient;
         R_DATA_O <= div.remainder;
         RETIRE_O <= div.done || do_unmask || do_halt
                     || (issue && !take_int && !dec_div);
      end
   end

   // program status word and return addresses
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         pstw     <= PSTW_RESET;
         irq_pc   <= PC_RESET;
         fatal_pc <= PC_RESET;
      end else begin
         if (REG_WR_I && hit_pstw) begin
            pstw <= REG_WDATA_I[PSTW_W-1:0];
         end
         if (div.done) begin
            pstw[PSTW_RANGE_ERR] <= dsr_zero;
            pstw[PSTW_SIGN]      <= div.quotient[31];
            pstw[PSTW_ZERO]      <= (div.quotient == 32'h0000_0000);
         end
         if (do_unmask) begin
            pstw[PSTW_IRQ_MASK] <= 1'b0;
         end
         if (any_int) begin
            pstw[PSTW_IRQ_MASK] <= 1'b1;
            if (take_nmi) begin
               fatal_pc <= ret_pc;
            end else begin
               irq_pc <= ret_pc;
            end
         end
      end
   end

   // acknowledge pulses, clock gate and ready
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         IRQ_ACK_O     <= 1'b0;
         NMI_ACK_O     <= 1'b0;
         CORE_CLK_EN_O <= 1'b1;
         INSTR_READY_O <= 1'b0;
      end else begin
         IRQ_ACK_O     <= any_int && !take_nmi;
         NMI_ACK_O     <= any_int && take_nmi;
         CORE_CLK_EN_O <= (next_state != ST_HALT);
         INSTR_READY_O <= (next_state == ST_IDLE);
      end
   end

   // event status with write-one-to-clear, set wins; mask register
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         status <= STATUS_RESET;
         mask   <= MASK_RESET;
         INT_O  <= 1'b0;
      end else begin
         if (REG_WR_I && hit_st) begin
            status <= (status & ~REG_WDATA_I[EV_W-1:0]) | events;
         end else begin
            status <= status | events;
         end
         if (REG_WR_I && hit_mask) begin
            mask <= REG_WDATA_I[EV_W-1:0];
         end
         INT_O <= |(status & mask);
      end
   end

   // register read port, data one cycle after strobe
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         REG_RDATA_O <= 32'h0000_0000;
      end else if (REG_RD_I) begin
         REG_RDATA_O <= hit_st   ? {28'h0, status}  :
                        hit_mask ? {28'h0, mask}    :
                        hit_pstw ? {26'h0, pstw}    :
                        hit_ipc  ? irq_pc           :
                        hit_fpc  ? fatal_pc         : 32'h0000_0000;
      end else begin
         REG_RDATA_O <= 32'h0000_0000;
      end
   end

   // status outputs
   assign PSTW_O     = pstw;
   assign IRQ_PC_O   = irq_pc;
   assign FATAL_PC_O = fatal_pc;
endmodule : dieh_decoder

/* File: testbench/dieh_decoder_sva.sv */
// port assertions for the divide / unmask / halt decoder
`timescale 1ns/1ps
module dieh_decoder_sva
   import dieh_pkg::*;
(
   input wire logic        CLK_I,         // clock
   input wire logic        RST_B_I,       // reset
   input wire logic [31:0] INSTR_I,       // word
   input wire logic        INSTR_VALID_I, // offered
   input wire logic        INSTR_READY_O, // idle
   input wire logic        REG_RD_I,      // read strobe
   input wire logic [31:0] REG_RDATA_O,   // read data
   input wire logic        Q_WE_O,        // quotient write
   input wire logic [4:0]  Q_ADDR_O,      // quotient reg
   input wire logic [31:0] Q_DATA_O,      // quotient
   input wire logic        R_WE_O,        // remainder write
   input wire logic [4:0]  R_ADDR_O,      // remainder reg
   input wire logic        RETIRE_O,      // retire
   input wire logic        IRQ_ACK_O,     // irq taken
   input wire logic        NMI_ACK_O,     // nmi taken
   input wire logic [5:0]  PSTW_O,        // status word
   input wire logic        CORE_CLK_EN_O  // clock enable
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   // issue steps
   sequence div_issue_s;
      INSTR_VALID_I && INSTR_READY_O && INSTR_I[10:5] == UDIV_LO_OP
         && INSTR_I[26:16] == UDIV_HI_OP;
   endsequence
   sequence halt_issue_s;
      INSTR_VALID_I && INSTR_READY_O && INSTR_I[30:0] == {HALT_HI, HALT_LO};
   endsequence
   div_hold_a: assert property (div_issue_s ##1 !INSTR_READY_O |->
      (!Q_WE_O && !R_WE_O && !RETIRE_O) [*8]) else $error("divide committed early");
   halt_stop_a: assert property (halt_issue_s ##1 (!IRQ_ACK_O && !NMI_ACK_O)
      |-> !CORE_CLK_EN_O) else $error("halt left clock running");
   halt_flags_a: assert property (!CORE_CLK_EN_O && !$past(CORE_CLK_EN_O)
      |-> $stable(PSTW_O)) else $error("flags moved while halted");
   halt_exit_a: assert property ($rose(CORE_CLK_EN_O) |-> IRQ_ACK_O || NMI_ACK_O)
      else $error("halt left without interrupt");
   irq_masked_a: assert property (IRQ_ACK_O |-> !$past(PSTW_O[PSTW_IRQ_MASK]))
      else $error("masked irq taken");
   ack_commit_a: assert property ((IRQ_ACK_O || NMI_ACK_O) |->
      !Q_WE_O && !R_WE_O && !RETIRE_O && PSTW_O[PSTW_IRQ_MASK]) else $error("ack with commit");
   same_reg_a: assert property (Q_WE_O |-> R_WE_O && Q_ADDR_O != R_ADDR_O)
      else $error("quotient write to remainder reg");
   div_flags_a: assert property (Q_WE_O |-> PSTW_O[PSTW_ZERO] == (Q_DATA_O == '0)
      && PSTW_O[PSTW_SIGN] == Q_DATA_O[31]) else $error("sign or zero flag wrong");
   commit_a: assert property (R_WE_O |-> RETIRE_O)
      else $error("write without retire");
   rdata_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == '0)
      else $error("read data outside read cycle");
endmodule : dieh_decoder_sva

bind dieh_decoder dieh_decoder_sva u_dieh_decoder_sva (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
   .INSTR_I(INSTR_I), .INSTR_VALID_I(INSTR_VALID_I), .INSTR_READY_O(INSTR_READY_O),
   .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .Q_WE_O(Q_WE_O), .Q_ADDR_O(Q_ADDR_O),
   .Q_DATA_O(Q_DATA_O), .R_WE_O(R_WE_O), .R_ADDR_O(R_ADDR_O), .RETIRE_O(RETIRE_O),
   .IRQ_ACK_O(IRQ_ACK_O), .NMI_ACK_O(NMI_ACK_O), .PSTW_O(PSTW_O),
   .CORE_CLK_EN_O(CORE_CLK_EN_O));

/* File: testbench/testbench.sv */
// self-checking bench for the divide / unmask / halt decoder
`timescale 1ns/1ps
module testbench;
   import dieh_pkg::*;
   typedef struct {logic [4:0] qf, rf; logic [31:0] dvd, dvs, q, r;} dieh_row_t;
   logic        clk = 1'b0, rst_b = 1'b0, vld = 1'b0, irq = 1'b0, nmi = 1'b0;
   logic        wr = 1'b0, rd = 1'b0;
   logic [31:0] ins = '0, pc = '0, dvd = '0, dvs = '0, wdata = '0, rv;
   logic [7:0]  addr = '0;
   logic [31:0] rdata, q_data, r_data, irq_pc, fatal_pc;
   logic        ready, q_we, r_we, retire, irq_ack, nmi_ack, clk_en, int_o;
   logic [4:0]  q_addr, r_addr;
   logic [5:0]  pstw, p0;
   int          mismatches = 0, num_checks = 0, n;
   dieh_row_t   rows [6] = '{'{2, 3, 100, 7, 14, 2}, '{4, 5, '1, 1, '1, 0},
      '{6, 7, 5, 9, 0, 5}, '{8, 9, 32'h8000_0000, 32'h0001_0000, 32'h8000, 0},
      '{10, 10, 50, 8, 6, 2}, '{11, 12, 7, 0, '1, 0}};
   // free-running core clock
   always #5 clk = ~clk;
   dieh_decoder u_dieh_decoder (.CLK_I(clk), .RST_B_I(rst_b), .INSTR_I(ins),
      .INSTR_VALID_I(vld), .PC_I(pc), .DIVIDEND_I(dvd), .DIVISOR_I(dvs), .IRQ_I(irq),
      .NMI_I(nmi), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdata), .INSTR_READY_O(ready), .Q_WE_O(q_we), .Q_ADDR_O(q_addr),
      .Q_DATA_O(q_data), .R_WE_O(r_we), .R_ADDR_O(r_addr), .R_DATA_O(r_data),
      .RETIRE_O(retire), .IRQ_ACK_O(irq_ack), .NMI_ACK_O(nmi_ack), .IRQ_PC_O(irq_pc),
      .FATAL_PC_O(fatal_pc), .PSTW_O(pstw), .CORE_CLK_EN_O(clk_en), .INT_O(int_o));
   task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   // register bus cycles
   task reg_w(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_w
   task reg_r(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : reg_r
   // one-cycle issue; operand buses scrambled afterwards
   task issue(input logic [31:0] w, input logic [31:0] p, input logic [31:0] a,
              input logic [31:0] b);
      @(posedge clk);
      vld <= 1'b1; ins <= w; pc <= p; dvd <= a; dvs <= b;
      @(posedge clk);
      vld <= 1'b0; dvd <= ~a; dvs <= ~b;
   endtask : issue
   // bounded wait: 0 retire, 1 irq ack, 2 nmi ack; count 0 if already showing
   task wait_out(input int sel, output int cnt);
      logic hit;
      cnt = -1;
      hit = 1'b0;
      while (!hit) begin
         if (cnt >= 0) begin
            @(posedge clk);
         end
         #1 cnt++;
         hit = (sel == 0) ? retire === 1'b1 : (sel == 1) ? irq_ack === 1'b1 : nmi_ack === 1'b1;
         if (!hit && cnt > 200) begin
            mismatches++;
            $display("FAIL wait %0d expected event seen none", sel);
            test_done();
         end
      end
   endtask : wait_out
   function automatic logic [31:0] div_word(input logic [4:0] qf, input logic [4:0] rf);
      return {rf, UDIV_HI_OP, qf, UDIV_LO_OP, 5'h01};
   endfunction : div_word
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      #1 check("pstw rst", pstw, PSTW_RESET);
      check("clk en rst", clk_en, 1'b1);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      reg_r(OFS_STATUS, rv); check("status", rv, STATUS_RESET);
      reg_r(OFS_MASK, rv); check("mask", rv, MASK_RESET);
      reg_w(OFS_FATAL_PC, '1); reg_r(OFS_FATAL_PC, rv); check("ro pc", rv, PC_RESET);
      reg_w(8'h14, '1); reg_r(8'h14, rv); check("unmapped", rv, 32'h0);
      reg_w(OFS_PSTW, 32'h38);
      for (int i = 0; i < 6; i++) begin
         issue(div_word(rows[i].qf, rows[i].rf), 32'h100 + 4 * i, rows[i].dvd, rows[i].dvs);
         wait_out(0, n);
         check("latency", n, DIV_CYCLES + 1);
         check("q we", q_we, rows[i].qf != rows[i].rf);
         check("r addr", {r_we, r_addr}, {1'b1, rows[i].rf});
         if (rows[i].qf != rows[i].rf) check("quot", {q_addr, q_data}, {rows[i].qf, rows[i].q});
         if (rows[i].dvs != 0) check("rem", r_data, rows[i].r);
         check("flags", pstw[2:0], {rows[i].dvs == 0, rows[i].q[31], rows[i].q == 0});
         check("kept", pstw[5:3], 3'b111);
      end
      for (int k = 0; k < 2; k++) begin
         issue(div_word(2, 3) ^ (k == 0 ? 32'h20 : 32'h1_0000), 32'h180, 9, 2);
         wait_out(0, n);
         check("miss", {n[1:0], q_we, r_we}, 4'h0);
      end
      irq <= 1'b1;
      issue(32'h0, 32'h200, 0, 0); wait_out(0, n);
      check("masked", n, 0);
      issue({UNMASK_HI, UNMASK_LO}, 32'h204, 0, 0); wait_out(0, n);
      check("unmask", pstw, 6'h1E);
      issue(32'h0, 32'h208, 0, 0); wait_out(1, n);
      check("irq at boundary", {n, irq_pc}, {32'd0, 32'h208});
      irq <= 1'b0;
      reg_w(OFS_PSTW, 32'h18); reg_w(OFS_STATUS, 32'hF);
      repeat (6) @(posedge clk);
      issue(div_word(2, 3), 32'h300, 100, 7);
      repeat (8) @(posedge clk);
      irq <= 1'b1;
      wait_out(1, n);
      check("abort pc", irq_pc, 32'h300);
      irq <= 1'b0;
      repeat (40) @(posedge clk);
      reg_r(OFS_STATUS, rv); check("abort status", rv, 32'h4);
      irq <= 1'b1;
      #1 p0 = pstw;
      issue({1'b0, HALT_HI, HALT_LO}, 32'h400, 0, 0);
      repeat (12) @(posedge clk);
      #1 check("halted", {clk_en, pstw}, {1'b0, p0});
      nmi <= 1'b1;
      wait_out(2, n);
      check("nmi exit", {clk_en, fatal_pc}, {1'b1, 32'h404});
      nmi <= 1'b0; irq <= 1'b0;
      reg_w(OFS_PSTW, 32'h00);
      repeat (6) @(posedge clk);
      issue({1'b0, HALT_HI, HALT_LO}, 32'h500, 0, 0);
      repeat (6) @(posedge clk);
      irq <= 1'b1;
      wait_out(1, n);
      check("irq exit", {clk_en, irq_pc}, {1'b1, 32'h504});
      irq <= 1'b0;
      check("int off", int_o, 1'b0);
      reg_w(OFS_MASK, 32'h8); repeat (2) @(posedge clk);
      #1 check("int on", int_o, 1'b1);
      reg_w(OFS_STATUS, 32'h8); repeat (2) @(posedge clk);
      #1 check("int clr", int_o, 1'b0);
      rst_b <= 1'b0;
      #1 check("pstw rst2", {clk_en, pstw}, {1'b1, PSTW_RESET});
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check("ready rst2", {ready, retire, irq_ack}, 3'b100);
      test_done();
   end
endmodule : testbench
